//--- logic/qsfm_clkdiv.sv
// serial clock tick generator from the divide factor
`timescale 1ns/1ps
`include "qsfm_defines.svh"
module qsfm_clkdiv
	import qsfm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic [`QSFM_DIV_W-1:0] serial_clock_divide_factor,
	output logic tick
);
	logic [`QSFM_DIV_W-1:0] cnt_r;
	// one tick per half period; divide factor d gives d+1 clocks per half
	always_ff @(posedge clk or negedge nrst) begin // see R11
		if (!nrst) begin
			cnt_r <= `QSFM_DIV_RST;
		end else if (ce) begin
			if (!run || cnt_r == serial_clock_divide_factor) begin
				cnt_r <= `QSFM_DIV_RST;
			end else begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
	assign tick = ce && run && (cnt_r == serial_clock_divide_factor);
endmodule : qsfm_clkdiv

//--- logic/qsfm_defines.svh
// timing counts, field widths and reset values for the quad flash master
`ifndef QSFM_DEFINES_SVH
`define QSFM_DEFINES_SVH
`define QSFM_WLEN_W 7
`define QSFM_WCNT_W 12
`define QSFM_DIV_W 8
`define QSFM_DLY_W 2
`define QSFM_DLY_MAX 2'h3
`define QSFM_MAX_BITS 128
`define QSFM_DIV_RST 8'h00
`define QSFM_CS_IDLE 1'b1
`define QSFM_MODE_SINGLE 2'h0
`define QSFM_MODE_DUAL 2'h1
`define QSFM_MODE_QUAD 2'h2
`define QSFM_PINS_3 2'h0
`define QSFM_PINS_4 2'h1
`define QSFM_PINS_6 2'h2
`define QSFM_CMD_W 32
`endif

//--- logic/qsfm_pkg.sv
// types shared by the quad flash master
`include "qsfm_defines.svh"
package qsfm_pkg;
	typedef enum logic [1:0] {QSFM_LN1, QSFM_LN2, QSFM_LN4, QSFM_LNX} qsfm_lanes_e;
	typedef enum logic [1:0] {QSFM_P3, QSFM_P4, QSFM_P6, QSFM_PX} qsfm_pins_e;
	typedef struct packed {
		logic [`QSFM_WLEN_W-1:0] wlen_m1;
		logic [`QSFM_WCNT_W-1:0] wcnt_m1;
		logic [`QSFM_DLY_W-1:0] cs_dly;
		qsfm_lanes_e lanes;
		qsfm_pins_e pins;
		logic word_irq_en;
		logic frame_irq_en;
	} qsfm_cfg_s;
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic [3:0] d_out;
		logic [3:0] d_oe_n;
	} qsfm_pin_s;
endpackage : qsfm_pkg

//--- logic/qsfm_top.sv
// quad serial flash master: framing, shifting and mapped reads
// Function
// R1: master only; always drives clock and chip select, never a target.
// R2: read words on one, two or four data lines, chosen per transfer.
// R3: mapped read request fetches a word without software sequencing.
// R4: word length programmable from 1 to 128 bits.
// R5: frame word count programmable from 1 to 4096 words.
// R6: separately enabled word-done and frame-done interrupts.
// R7: zero to three serial clocks between chip select and first data.
// R8: three, four and six pin configurations supported.
// R9: clock mode zero, clock idles low, phase zero.
// R10: incoming data sampled on the falling serial clock edge.
// R11: serial clock from a divide factor; odd factor gives even duty.
// R12: chip select held across the frame, released after last edge.
`timescale 1ns/1ps
`include "qsfm_defines.svh"
module qsfm_top
	import qsfm_pkg::*;
(
	input wire logic CLK,
	input wire logic NRST,
	input wire logic CE,
	input wire logic [`QSFM_DIV_W-1:0] DIV_FACTOR,
	input wire logic [`QSFM_WLEN_W-1:0] WLEN_M1,
	input wire logic [`QSFM_WCNT_W-1:0] WCNT_M1,
	input wire logic [`QSFM_DLY_W-1:0] CS_DLY,
	input wire logic [1:0] LANES,
	input wire logic [1:0] PINS,
	input wire logic WORD_IRQ_EN,
	input wire logic FRAME_IRQ_EN,
	input wire logic START,
	input wire logic MAP_REQ,
	input wire logic [`QSFM_CMD_W-1:0] MAP_ADDR,
	output logic BUSY,
	output logic MAP_ACK,
	output logic [`QSFM_MAX_BITS-1:0] RDATA,
	output logic RDATA_VLD,
	output logic WORD_IRQ,
	output logic FRAME_IRQ,
	output logic SCLK,
	output logic CS_N,
	output logic [3:0] D_OUT,
	output logic [3:0] D_OE_N,
	input wire logic [3:0] D_IN
);
	typedef enum logic [2:0] {S_IDLE, S_CMD, S_DLY, S_DATA, S_END} qsfm_st_e;
	qsfm_st_e st_r;
	qsfm_cfg_s cfg_r;
	logic tick;
	logic sclk_r, cs_n_r, map_r;
	logic [`QSFM_CMD_W-1:0] cmd_r;
	logic [5:0] cmd_cnt_r;
	logic [`QSFM_DLY_W-1:0] dly_r;
	logic [`QSFM_WLEN_W:0] bit_r;
	logic [`QSFM_WCNT_W-1:0] word_r;
	logic [`QSFM_MAX_BITS-1:0] sh_r;
	logic [`QSFM_WLEN_W:0] step;
	logic word_end, fall;
	logic start_any;
	assign start_any = (START || MAP_REQ) && st_r == S_IDLE;
	assign fall = tick && sclk_r;
	qsfm_clkdiv u_div (
		.clk(CLK),
		.nrst(NRST),
		.ce(CE),
		.run(st_r != S_IDLE),
		.serial_clock_divide_factor(DIV_FACTOR),
		.tick(tick)
	);
	// bits per falling edge by lane count
	always_comb begin // see R2
		unique case (cfg_r.lanes)
			QSFM_LN2: step = 8'h02;
			QSFM_LN4: step = 8'h04;
			default: step = 8'h01;
		endcase
	end
	assign word_end = fall && st_r == S_DATA &&
		({1'b0, bit_r} + {1'b0, step} > {2'h0, cfg_r.wlen_m1});
	// capture config per transfer; mapped read forces one word
	always_ff @(posedge CLK or negedge NRST) begin // see R3
		if (!NRST) begin
			cfg_r <= '0;
			map_r <= 1'b0;
			cmd_r <= '0;
		end else if (CE && start_any) begin
			cfg_r.wlen_m1 <= WLEN_M1;
			cfg_r.wcnt_m1 <= MAP_REQ ? 12'h000 : WCNT_M1; // see R5
			cfg_r.cs_dly <= CS_DLY;
			cfg_r.lanes <= qsfm_lanes_e'(LANES);
			cfg_r.pins <= qsfm_pins_e'(PINS); // see R8
			cfg_r.word_irq_en <= WORD_IRQ_EN;
			cfg_r.frame_irq_en <= FRAME_IRQ_EN;
			map_r <= MAP_REQ;
			cmd_r <= MAP_ADDR;
		end else if (CE && fall && st_r == S_CMD) begin
			cmd_r <= {cmd_r[`QSFM_CMD_W-2:0], 1'b0};
		end
	end
	// sequencer
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			st_r <= S_IDLE;
			cmd_cnt_r <= 6'h00;
			dly_r <= 2'h0;
			bit_r <= 8'h00;
			word_r <= 12'h000;
		end else if (CE) begin
			unique case (st_r)
				S_IDLE: if (start_any) begin
					st_r <= (MAP_REQ || CS_DLY != 2'h0) ?
						(MAP_REQ ? S_CMD : S_DLY) : S_DATA;
					dly_r <= CS_DLY;
					cmd_cnt_r <= 6'h00;
					bit_r <= 8'h00;
					word_r <= 12'h000;
				end
				S_CMD: if (fall) begin
					cmd_cnt_r <= cmd_cnt_r + 6'h01;
					if (cmd_cnt_r == 6'h1f) begin
						st_r <= (cfg_r.cs_dly != 2'h0) ? S_DLY : S_DATA;
					end
				end
				S_DLY: if (fall) begin // see R7
					dly_r <= dly_r - 2'h1;
					if (dly_r == 2'h1) begin
						st_r <= S_DATA;
					end
				end
				S_DATA: if (word_end) begin // see R4
					bit_r <= 8'h00;
					word_r <= word_r + 12'h001;
					if (word_r == cfg_r.wcnt_m1) begin
						st_r <= S_END;
					end
				end else if (fall) begin
					bit_r <= bit_r + step;
				end
				S_END: if (tick) begin // see R12
					st_r <= S_IDLE;
				end
				default: st_r <= S_IDLE;
			endcase
		end
	end
	// clock mode zero: low at idle, toggles while active
	always_ff @(posedge CLK or negedge NRST) begin // see R9
		if (!NRST) begin
			sclk_r <= 1'b0;
		end else if (CE) begin
			if (st_r == S_IDLE || st_r == S_END) begin
				sclk_r <= 1'b0;
			end else if (tick) begin
				sclk_r <= ~sclk_r;
			end
		end
	end
	// chip select held through every word of the frame
	always_ff @(posedge CLK or negedge NRST) begin // see R12
		if (!NRST) begin
			cs_n_r <= `QSFM_CS_IDLE;
		end else if (CE) begin
			cs_n_r <= !(start_any || (st_r != S_IDLE &&
				!(st_r == S_END && tick)));
		end
	end
	// sample on falling serial edge, lanes per mode
	always_ff @(posedge CLK or negedge NRST) begin // see R10
		if (!NRST) begin
			sh_r <= '0;
		end else if (CE && fall && st_r == S_DATA) begin
			unique case (cfg_r.lanes)
				QSFM_LN2: sh_r <= {sh_r[`QSFM_MAX_BITS-3:0], D_IN[1:0]};
				QSFM_LN4: sh_r <= {sh_r[`QSFM_MAX_BITS-5:0], D_IN};
				default: sh_r <= {sh_r[`QSFM_MAX_BITS-2:0], D_IN[1]};
			endcase
		end
	end
	// word results and interrupts
	always_ff @(posedge CLK or negedge NRST) begin // see R6
		if (!NRST) begin
			RDATA <= '0;
			RDATA_VLD <= 1'b0;
			WORD_IRQ <= 1'b0;
			FRAME_IRQ <= 1'b0;
			MAP_ACK <= 1'b0;
		end else if (CE) begin
			RDATA_VLD <= word_end;
			WORD_IRQ <= word_end && cfg_r.word_irq_en;
			FRAME_IRQ <= st_r == S_END && tick && cfg_r.frame_irq_en;
			MAP_ACK <= word_end && map_r;
			if (word_end) begin
				unique case (cfg_r.lanes)
					QSFM_LN2: RDATA <= {sh_r[`QSFM_MAX_BITS-3:0], D_IN[1:0]};
					QSFM_LN4: RDATA <= {sh_r[`QSFM_MAX_BITS-5:0], D_IN};
					default: RDATA <= {sh_r[`QSFM_MAX_BITS-2:0], D_IN[1]};
				endcase
			end
		end
	end
	// master drives clock and select, and the command line on D[0] except in 3-pin; other data lines inputs
	always_comb begin // see R1
		D_OUT = {3'h0, cmd_r[`QSFM_CMD_W-1]};
		D_OE_N = 4'hf;
		if (st_r == S_CMD && cfg_r.pins != QSFM_P3) begin // see R8
			D_OE_N = 4'he;
		end
	end
	assign SCLK = sclk_r;
	assign CS_N = cs_n_r;
	assign BUSY = st_r != S_IDLE;

	property p_idle_clk;
		@(posedge CLK) disable iff (!NRST)
		(st_r == S_IDLE) |-> !SCLK;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock not idle low"); // see R9
	property p_cs_busy;
		@(posedge CLK) disable iff (!NRST)
		(BUSY && $past(BUSY)) |-> !CS_N;
	endproperty
	a_cs_busy: assert property (p_cs_busy) else $error("select dropped mid frame"); // see R12
	property p_word_irq;
		@(posedge CLK) disable iff (!NRST)
		(CE && word_end && cfg_r.word_irq_en) |=> WORD_IRQ;
	endproperty
	a_word_irq: assert property (p_word_irq) else $error("word irq missing"); // see R6
	property p_frame_gate;
		@(posedge CLK) disable iff (!NRST)
		FRAME_IRQ |-> $past(cfg_r.frame_irq_en);
	endproperty
	a_frame_gate: assert property (p_frame_gate) else $error("frame irq ungated"); // see R6
	sequence s_data_fall;
		CE && st_r == S_DATA && fall && !word_end;
	endsequence
	property p_sample;
		@(posedge CLK) disable iff (!NRST)
		s_data_fall |=> bit_r == $past(bit_r) + $past(step);
	endproperty
	a_sample: assert property (p_sample) else $error("bit count wrong"); // see R10
	property p_no_dly;
		@(posedge CLK) disable iff (!NRST)
		(CE && START && !MAP_REQ && st_r == S_IDLE && CS_DLY == 2'h0)
			|=> st_r == S_DATA;
	endproperty
	a_no_dly: assert property (p_no_dly) else $error("zero delay skipped"); // see R7
	property p_dly;
		@(posedge CLK) disable iff (!NRST)
		(st_r == S_DLY) |-> !CS_N && D_OE_N == 4'hf;
	endproperty
	a_dly: assert property (p_dly) else $error("data during delay"); // see R7
	property p_map_one;
		@(posedge CLK) disable iff (!NRST)
		MAP_ACK |-> RDATA_VLD && st_r == S_END;
	endproperty
	a_map_one: assert property (p_map_one) else $error("map ack alone"); // see R3
	property p_three_pin;
		@(posedge CLK) disable iff (!NRST)
		(cfg_r.pins == QSFM_P3) |-> D_OE_N == 4'hf;
	endproperty
	a_three_pin: assert property (p_three_pin) else $error("3-pin drove data"); // see R8
endmodule : qsfm_top

//--- verif/qsfm_flash_model.sv
// flash partner model driving read data
`timescale 1ns/1ps
module qsfm_flash_model (
	input wire logic sclk,
	input wire logic cs_n,
	output logic [3:0] d_in
);
	logic [3:0] nxt = 4'h5;
	initial d_in = 4'h5;
	// launch after falling edge, held past it
	always @(negedge sclk) begin
		nxt = nxt * 4'h5 + 4'h3;
		d_in <= #1 nxt;
	end
	// deselected: show inverse, not stale data
	always @(posedge cs_n) d_in <= #1 ~d_in;
endmodule : qsfm_flash_model

//--- verif/qsfm_top_tb.sv
// self-checking bench for the quad flash master
`timescale 1ns/1ps
module qsfm_top_tb;
	import qsfm_pkg::*;
	logic CLK = 0, NRST = 0, CE = 1, START = 0, MAP_REQ = 0;
	logic WORD_IRQ_EN = 0, FRAME_IRQ_EN = 0;
	logic [7:0] DIV_FACTOR = 8'h00;
	logic [6:0] WLEN_M1 = 7'h00;
	logic [11:0] WCNT_M1 = 12'h000;
	logic [1:0] CS_DLY = 2'h0, LANES = 2'h0, PINS = 2'h0;
	logic [31:0] MAP_ADDR = 32'h0, cmd;
	logic BUSY, MAP_ACK, RDATA_VLD, WORD_IRQ, FRAME_IRQ, SCLK, CS_N;
	logic [127:0] RDATA, acc, msk;
	logic [3:0] D_OUT, D_OE_N, D_IN, lm;
	int bad_count = 0, checks = 0, nw, nwi, nfi, nm, ncs, hcnt = 0;
	always #2 CLK = ~CLK;
	qsfm_top dut (.CLK, .NRST, .CE, .DIV_FACTOR, .WLEN_M1, .WCNT_M1,
		.CS_DLY, .LANES, .PINS, .WORD_IRQ_EN, .FRAME_IRQ_EN, .START,
		.MAP_REQ, .MAP_ADDR, .BUSY, .MAP_ACK, .RDATA, .RDATA_VLD,
		.WORD_IRQ, .FRAME_IRQ, .SCLK, .CS_N, .D_OUT, .D_OE_N, .D_IN);
	qsfm_flash_model flash (.sclk(SCLK), .cs_n(CS_N), .d_in(D_IN));
	task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic close_out();
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	// reference shift register of what the flash put on the lanes
	assign lm = LANES == 2'h0 ? 4'h2 : LANES == 2'h1 ? 4'h3 : 4'hf;
	always @(negedge SCLK) if (!CS_N && (D_OE_N & lm) === lm) begin
		case (LANES)
		2'h0: acc = {acc[126:0], D_IN[1]};
		2'h1: acc = {acc[125:0], D_IN[1:0]};
		default: acc = {acc[123:0], D_IN};
		endcase
	end
	always @(posedge SCLK) if (D_OE_N[0] === 1'b0) cmd = {cmd[30:0], D_OUT[0]};
	always @(posedge CS_N) ncs++;
	always @(negedge CLK) if (NRST) begin
		if (SCLK === 1'b1) hcnt++;
		else if (hcnt > 0) begin
			chk("sclk_high", DIV_FACTOR + 1, hcnt);
			hcnt = 0;
		end
		if (CS_N === 1'b1) chk("sclk_idle", 0, SCLK);
		if (RDATA_VLD === 1'b1) begin
			chk("rdata", acc & msk, RDATA & msk);
			acc = 0;
			nw++;
		end
		if (WORD_IRQ === 1'b1) nwi++;
		if (FRAME_IRQ === 1'b1) nfi++;
		if (MAP_ACK === 1'b1) nm++;
	end
	task automatic run(logic m);
		int i;
		nw = 0; nwi = 0; nfi = 0; nm = 0; ncs = 0; acc = 0;
		msk = ~(~128'h0 << WLEN_M1 << 1);
		START = !m;
		MAP_REQ = m;
		@(negedge CLK);
		START = 0;
		MAP_REQ = 0;
		chk("busy", 1, BUSY);
		chk("cs_on", 0, CS_N);
		// freeze the frame, then a start while busy must be ignored
		CE = 0;
		repeat (4) @(negedge CLK);
		chk("frz_busy", 1, BUSY);
		chk("frz_cs", 0, CS_N);
		chk("frz_sclk", 0, SCLK);
		CE = 1;
		START = 1;
		@(negedge CLK);
		START = 0;
		for (i = 0; i < 20000 && BUSY !== 1'b0; i++) @(negedge CLK);
		// let the monitor count the last pulses first
		@(negedge CLK);
		chk("done", 0, BUSY);
		chk("cs_rel", 1, ncs);
		if (m) begin
			chk("ack", 1, nm);
			chk("mwords", 1, nw);
			if (PINS != 2'h0) chk("cmd", MAP_ADDR, cmd);
		end else begin
			chk("words", WCNT_M1 + 1, nw);
			chk("wirq", WORD_IRQ_EN ? nw : 0, nwi);
			chk("firq", FRAME_IRQ_EN, nfi);
		end
	endtask : run
	initial begin
		#320000;
		bad_count++;
		close_out();
	end
	initial begin
		void'($urandom(34697));
		repeat (4) @(negedge CLK);
		NRST = 1;
		for (int k = 0; k < 14; k++) begin
			LANES = k % 3;
			PINS = (k / 3) % 3;
			WLEN_M1 = k == 0 ? 7'h00 : k == 1 ? 7'h7f : 7'($urandom % 32 * 4 + 3);
			WCNT_M1 = 12'($urandom % 3);
			DIV_FACTOR = 8'($urandom % 4);
			CS_DLY = 2'($urandom);
			WORD_IRQ_EN = 1'($urandom);
			FRAME_IRQ_EN = 1'($urandom);
			MAP_ADDR = $urandom;
			run(0);
			run(1);
		end
		close_out();
	end
endmodule : qsfm_top_tb
